// ---- logic/radio_queue_pkg.sv ----
// Purpose: Shared constants for the radio queue port and status block.
// Assumes: One system clock, synchronous active-high reset.
// Notes: Offsets are special-function-register addresses on the CPU bus.
package radio_queue_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] MASK_ADDR = 8'h91;
	localparam logic [7:0] DATA_PORT_ADDR = 8'hd9;
	localparam logic [7:0] FLAGS_ADDR = 8'he9;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// ****************************************
	// Interrupt source bit positions
	// ****************************************
	localparam int BIT_REGULATOR_ON = 7;
	localparam int BIT_TRANSMIT_COMPLETE = 6;
	localparam int BIT_RX_THRESHOLD = 5;
	localparam int BIT_DELIMITER_SEEN = 4;
	// Sources that arrive ready-made from the rest of the radio.
	localparam logic [7:0] EXTERNAL_SOURCES = 8'h8f;
	// ****************************************
	// Queue geometry
	// ****************************************
	localparam int QUEUE_DEPTH = 128;
	localparam int PTR_W = 7;
	localparam int COUNT_W = 8;
	localparam logic [7:0] QUEUE_FULL_COUNT = 8'h80;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [6:0] PTR_RESET = 7'h00;
endpackage

// ---- logic/radio_queue_port_status.sv ----
// Purpose: Byte port onto the radio transmit and receive queues, with status and interrupt mask.
// Assumes: All inputs come from logic on sys_clk; the CPU bus gives one-cycle strobes.
// Notes: Receive status flags describe only the receive queue.
`timescale 1ns/1ps
// Overview of operation
// - Eight-bit read/write interrupt mask, cleared at reset, one enable per source.
// - Transmit-complete source also raised for sent acknowledges when selected.
// - Each write to the data port pushes the byte into the transmit queue unless it is full or being flushed.
// - Each read of the data port with bytes queued returns and removes the next receive byte.
// - Transmit flush strobe empties the transmit queue.
// - Receive flush strobe empties the receive queue.
// - Separate 128-byte receive and transmit queues; several frames may share receive.
// - DMA trigger fires when the receive queue goes from empty to non-empty.
// - DMA trigger fires when a read leaves at least one byte behind.
// - Delimiter received sets its interrupt flag and raises the delimiter status bit.
// - Delimiter status stays high until the last frame byte when address accepted.
// - Delimiter status drops at once when address recognition fails.
// - Length byte stored first; non-empty bit high from then until queue empty.
// - A readable count of bytes held in the receive queue is provided.
// - Threshold bit high when unread bytes exceed the programmed threshold.
// - With address recognition on, threshold bit waits for address acceptance.
// - Threshold bit rises on a frame's last byte; clears after one byte read.
// - Address failure leaves the frame's bytes in the receive queue; readers wait for the threshold bit.
// - Receive overflow raises the radio error interrupt when enabled.
// - On overflow, non-empty bit low while threshold bit high.
// - Overflow leaves bytes already queued intact and readable.
// - After overflow, no receive data is taken until a receive flush.
// - Masking a source does not stop its flag from updating.
// - Combined interrupt pulses on the rising edge of each enabled flag.
module radio_queue_port_status
	import radio_queue_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Special-function-register bus.
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Command strobes and configuration.
	input wire logic flush_transmit_strobe,
	input wire logic flush_receive_strobe,
	input wire logic [6:0] rx_threshold_setting,
	input wire logic addr_recog_enable,
	input wire logic ack_done_source_select,
	input wire logic error_irq_enable,
	// Demodulator side.
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_delimiter_done,
	input wire logic rx_frame_end,
	input wire logic rx_addr_pass,
	input wire logic rx_addr_fail,
	// Modulator side.
	input wire logic tx_pop,
	output logic [7:0] tx_head,
	output logic tx_queue_nonempty,
	// Other radio interrupt sources.
	input wire logic [7:0] other_source_events,
	input wire logic tx_done_event,
	input wire logic tx_ack_done_event,
	// Status and events.
	output logic delimiter_active_flag,
	output logic rx_queue_nonempty_flag,
	output logic rx_threshold_flag,
	output logic [7:0] rx_byte_count,
	output logic [7:0] radio_interrupt_flags,
	output logic radio_interrupt,
	output logic radio_error_interrupt,
	output logic dma_trigger
);
	// Queue storage; each queue is its own array.
	logic [7:0] rx_mem [QUEUE_DEPTH];
	logic [7:0] tx_mem [QUEUE_DEPTH];
	logic [PTR_W-1:0] rx_wr_q, rx_rd_q, tx_wr_q, tx_rd_q;
	logic [COUNT_W-1:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
	logic [7:0] mask_q, flags_q, flags_d, rdata_q, tx_head_q;
	logic overflow_q, addr_ok_q, frame_done_q, delim_q, thr_q, thr_d;
	logic irq_q, err_q, dma_q, rx_ne_q, tx_ne_q;

	function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
		ptr_next = p + 7'h01;
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************
	// Strobes decoded once and shared by the queues and register logic.
	wire wr_mask = sfr_wr && (sfr_addr == MASK_ADDR);
	wire wr_flags = sfr_wr && (sfr_addr == FLAGS_ADDR);
	wire wr_port = sfr_wr && (sfr_addr == DATA_PORT_ADDR);
	wire rd_port = sfr_rd && (sfr_addr == DATA_PORT_ADDR);
	wire [7:0] rd_mux = (sfr_addr == MASK_ADDR) ? mask_q :
		(sfr_addr == FLAGS_ADDR) ? flags_q :
		(sfr_addr == DATA_PORT_ADDR) ? rx_mem[rx_rd_q] : UNMAPPED_READ;

	// ****************************************
	// Receive queue
	// ****************************************
	// A full queue or a standing overflow drops the byte rather than overwrite data.
	wire rx_full = (rx_cnt_q == QUEUE_FULL_COUNT);
	wire rx_empty = (rx_cnt_q == COUNT_RESET);
	wire rx_push = rx_byte_valid && !rx_full && !overflow_q && !flush_receive_strobe;
	wire rx_over = rx_byte_valid && rx_full && !flush_receive_strobe;
	wire rx_pop = rd_port && !rx_empty && !flush_receive_strobe;
	wire overflow_d = rx_over || (overflow_q && !flush_receive_strobe);
	always_comb begin
		rx_cnt_d = rx_cnt_q;
		if (flush_receive_strobe) begin
			rx_cnt_d = COUNT_RESET;
		end else if (rx_push && !rx_pop) begin
			rx_cnt_d = rx_cnt_q + 8'h01;
		end else if (rx_pop && !rx_push) begin
			rx_cnt_d = rx_cnt_q - 8'h01;
		end
	end

	// Pointers wrap naturally over the 128 entries.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_wr_q <= PTR_RESET;
			rx_rd_q <= PTR_RESET;
		end else if (flush_receive_strobe) begin
			rx_wr_q <= PTR_RESET;
			rx_rd_q <= PTR_RESET;
		end else begin
			if (rx_push) begin
				rx_wr_q <= ptr_next(rx_wr_q);
			end
			if (rx_pop) begin
				rx_rd_q <= ptr_next(rx_rd_q);
			end
		end
	end

	// Storage has no reset; only the pointers and count define content.
	always_ff @(posedge sys_clk) begin
		if (rx_push) begin
			rx_mem[rx_wr_q] <= rx_byte;
		end
		if (wr_port && tx_cnt_q != QUEUE_FULL_COUNT && !flush_transmit_strobe) begin
			tx_mem[tx_wr_q] <= sfr_wdata;
		end
	end

	// Overflow holds until a receive flush.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_cnt_q <= COUNT_RESET;
			overflow_q <= 1'b0;
			rx_ne_q <= 1'b0;
		end else begin
			rx_cnt_q <= rx_cnt_d;
			overflow_q <= overflow_d;
			rx_ne_q <= (rx_cnt_d != COUNT_RESET) && !overflow_d;
		end
	end

	// ****************************************
	// Transmit queue
	// ****************************************
	// Writes into a full transmit queue are dropped.
	wire tx_push = wr_port && tx_cnt_q != QUEUE_FULL_COUNT && !flush_transmit_strobe;
	wire tx_take = tx_pop && tx_cnt_q != COUNT_RESET && !flush_transmit_strobe;
	wire [PTR_W-1:0] tx_head_ptr = tx_take ? ptr_next(tx_rd_q) : tx_rd_q;
	always_comb begin
		tx_cnt_d = tx_cnt_q;
		if (flush_transmit_strobe) begin
			tx_cnt_d = COUNT_RESET;
		end else if (tx_push && !tx_take) begin
			tx_cnt_d = tx_cnt_q + 8'h01;
		end else if (tx_take && !tx_push) begin
			tx_cnt_d = tx_cnt_q - 8'h01;
		end
	end

	// Head byte follows a pop in the same cycle but lags the non-empty bit by one; for one cycle after emptying it can show unwritten storage, then zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_wr_q <= PTR_RESET;
			tx_rd_q <= PTR_RESET;
			tx_cnt_q <= COUNT_RESET;
			tx_head_q <= DATA_RESET;
			tx_ne_q <= 1'b0;
		end else begin
			tx_cnt_q <= tx_cnt_d;
			tx_ne_q <= (tx_cnt_d != COUNT_RESET);
			tx_head_q <= tx_ne_q ? tx_mem[tx_head_ptr] : DATA_RESET;
			if (flush_transmit_strobe) begin
				tx_wr_q <= PTR_RESET;
				tx_rd_q <= PTR_RESET;
			end else begin
				tx_wr_q <= tx_push ? ptr_next(tx_wr_q) : tx_wr_q;
				tx_rd_q <= tx_take ? ptr_next(tx_rd_q) : tx_rd_q;
			end
		end
	end

	// ****************************************
	// Frame status
	// ****************************************
	// Threshold needs address acceptance; a frame end raises it regardless.
	wire addr_ok = !addr_recog_enable || addr_ok_q;
	always_comb begin
		thr_d = (rx_cnt_d > {1'b0, rx_threshold_setting}) && addr_ok;
		if (rx_frame_end || (frame_done_q && !rx_pop)) begin
			thr_d = 1'b1;
		end
		if (overflow_d) begin
			thr_d = 1'b1;
		end
	end

	// Set wins over clear for every event-driven flag here.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			addr_ok_q <= 1'b0;
			frame_done_q <= 1'b0;
			delim_q <= 1'b0;
			thr_q <= 1'b0;
		end else begin
			addr_ok_q <= rx_addr_pass || (addr_ok_q && !rx_delimiter_done);
			frame_done_q <= rx_frame_end || (frame_done_q && !rx_pop && !flush_receive_strobe);
			delim_q <= rx_delimiter_done || (delim_q && !rx_frame_end && !rx_addr_fail);
			thr_q <= thr_d;
		end
	end

	// ****************************************
	// Interrupt flags, mask and events
	// ****************************************
	// Flags update whatever the mask says; a zero written clears, a new event wins.
	wire [7:0] flag_set = (other_source_events & EXTERNAL_SOURCES) |
		({7'h00, tx_done_event || (tx_ack_done_event && ack_done_source_select)}
			<< BIT_TRANSMIT_COMPLETE) |
		({7'h00, thr_d && !thr_q} << BIT_RX_THRESHOLD) |
		({7'h00, rx_delimiter_done} << BIT_DELIMITER_SEEN);
	wire [7:0] flag_keep = wr_flags ? (flags_q & sfr_wdata) : flags_q;
	assign flags_d = flag_keep | flag_set;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mask_q <= MASK_RESET;
			flags_q <= FLAGS_RESET;
			irq_q <= 1'b0;
			err_q <= 1'b0;
			dma_q <= 1'b0;
			rdata_q <= DATA_RESET;
		end else begin
			mask_q <= wr_mask ? sfr_wdata : mask_q;
			flags_q <= flags_d;
			irq_q <= |(flags_d & ~flags_q & mask_q);
			err_q <= rx_over && !overflow_q && error_irq_enable;
			dma_q <= (rx_push && rx_empty) || (rx_pop && rx_cnt_d != COUNT_RESET);
			rdata_q <= sfr_rd ? rd_mux : rdata_q;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sfr_rdata = rdata_q;
	assign tx_head = tx_head_q;
	assign tx_queue_nonempty = tx_ne_q;
	assign delimiter_active_flag = delim_q;
	assign rx_queue_nonempty_flag = rx_ne_q;
	assign rx_threshold_flag = thr_q;
	assign rx_byte_count = rx_cnt_q;
	assign radio_interrupt_flags = flags_q;
	assign radio_interrupt = irq_q;
	assign radio_error_interrupt = err_q;
	assign dma_trigger = dma_q;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_fill_first;
		rx_push && rx_empty;
	endsequence
	property p_mask_write;
		@(posedge sys_clk) disable iff (rst) wr_mask |=> mask_q == $past(sfr_wdata);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask not written");
	property p_dma_first;
		@(posedge sys_clk) disable iff (rst) s_fill_first |=> dma_trigger;
	endproperty
	a_dma_first: assert property (p_dma_first) else $error("no dma on first byte");
	property p_dma_left;
		@(posedge sys_clk) disable iff (rst)
			rx_pop && !rx_push && rx_cnt_q > 8'h01 |=> dma_trigger;
	endproperty
	a_dma_left: assert property (p_dma_left) else $error("no dma after read");
	property p_rx_flush;
		@(posedge sys_clk) disable iff (rst) flush_receive_strobe |=> rx_byte_count == 8'h00;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("receive flush failed");
	property p_tx_flush;
		@(posedge sys_clk) disable iff (rst) flush_transmit_strobe |=> !tx_queue_nonempty;
	endproperty
	a_tx_flush: assert property (p_tx_flush) else $error("transmit flush failed");
	property p_overflow_mark;
		@(posedge sys_clk) disable iff (rst)
			overflow_q |-> !rx_queue_nonempty_flag ##1 (rx_threshold_flag || $past(flush_receive_strobe));
	endproperty
	a_overflow_mark: assert property (p_overflow_mark) else $error("overflow marking wrong");
	property p_overflow_hold;
		@(posedge sys_clk) disable iff (rst)
			overflow_q && !flush_receive_strobe && !rx_pop |=> $stable(rx_byte_count);
	endproperty
	a_overflow_hold: assert property (p_overflow_hold) else $error("data taken in overflow");
	property p_delim_fail;
		@(posedge sys_clk) disable iff (rst)
			rx_addr_fail && !rx_delimiter_done |=> !delimiter_active_flag;
	endproperty
	a_delim_fail: assert property (p_delim_fail) else $error("delimiter not dropped");
	property p_delim_flag;
		@(posedge sys_clk) disable iff (rst)
			rx_delimiter_done |=> radio_interrupt_flags[BIT_DELIMITER_SEEN] && delimiter_active_flag;
	endproperty
	a_delim_flag: assert property (p_delim_flag) else $error("delimiter flag missing");
	property p_irq_edge;
		@(posedge sys_clk) disable iff (rst)
			radio_interrupt |->
				|(radio_interrupt_flags & ~$past(radio_interrupt_flags) & $past(mask_q));
	endproperty
	a_irq_edge: assert property (p_irq_edge) else $error("interrupt without enabled edge");
	property p_empty_read;
		@(posedge sys_clk) disable iff (rst)
			rd_port && rx_empty && !rx_byte_valid && !flush_receive_strobe |=> rx_byte_count == 8'h00;
	endproperty
	a_empty_read: assert property (p_empty_read) else $error("empty read changed count");
endmodule

// ---- testbench/cpu_bus_model.sv ----
// Purpose: CPU register bus master standing in for the core and DMA.
// Assumes: One-cycle read and write strobes taken on sys_clk.
// Notes: Released write data shows the inverse of the last byte.
`timescale 1ns/1ps
module cpu_bus_model (
	// Clock.
	input wire logic sys_clk,
	// Register bus.
	output logic [7:0] sfr_addr,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_wdata
);
	// ****************************************
	// Bus cycles
	// ****************************************
	// Idle bus at time zero.
	initial begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	// Write strobe; data is scrambled after release so a stale byte never passes.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		sfr_wdata <= ~d;
	endtask
	// Read strobe; the answer is sampled by the bench one cycle later.
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
	endtask
endmodule

// ---- testbench/tb_radio_queue_port_status.sv ----
// Purpose: Self-checking bench for the radio queue port and status block.
// Assumes: Demodulator pulses and bus strobes change on the rising edge.
// Notes: Read data is checked against a queue of expected bytes.
`timescale 1ns/1ps
module tb_radio_queue_port_status;
	import radio_queue_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rx_byte, tx_head, rx_byte_count, flg, lf, b0, b1;
	logic sfr_wr, sfr_rd, rxv, are, asel, ee, txne, sfd, ne, tf, irq, err, dma;
	logic rd_pend = 1'b0;
	logic [6:0] ev_q, thr;
	logic [7:0] exp_q[$];
	int mismatches = 0, n_checks = 0, cyc = 0, irq_n = 0, err_n = 0;
	always #12.5 sys_clk = ~sys_clk;
	cpu_bus_model cpu (.sys_clk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata);
	radio_queue_port_status uut (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata, .flush_transmit_strobe(ev_q[5]), .flush_receive_strobe(ev_q[4]),
		.rx_threshold_setting(thr), .addr_recog_enable(are), .ack_done_source_select(asel),
		.error_irq_enable(ee), .rx_byte_valid(rxv), .rx_byte, .rx_delimiter_done(ev_q[0]),
		.rx_frame_end(ev_q[1]), .rx_addr_pass(ev_q[2]), .rx_addr_fail(ev_q[3]),
		.tx_pop(1'b0), .tx_head, .tx_queue_nonempty(txne), .other_source_events(8'h00),
		.tx_done_event(1'b0), .tx_ack_done_event(ev_q[6]), .delimiter_active_flag(sfd),
		.rx_queue_nonempty_flag(ne), .rx_threshold_flag(tf), .rx_byte_count,
		.radio_interrupt_flags(flg), .radio_interrupt(irq), .radio_error_interrupt(err),
		.dma_trigger(dma));
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] ex);
		n_checks++;
		if (got !== ex) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, ex);
		end
	endtask
	task automatic cmp1(input logic got, input logic ex);
		cmp8({7'h00, got}, {7'h00, ex});
	endtask
	task automatic clk(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// One-cycle event pulses, checked just after the taking edge settles.
	task automatic ev(input logic [6:0] m);
		@(posedge sys_clk);
		ev_q <= m;
		@(posedge sys_clk);
		ev_q <= 7'h00;
		#1;
	endtask
	task automatic rx(input logic [7:0] d);
		@(posedge sys_clk);
		rxv <= 1'b1;
		rx_byte <= d;
		@(posedge sys_clk);
		rxv <= 1'b0;
		rx_byte <= ~d;
		#1;
	endtask
	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		cpu.rd(a);
		#1;
	endtask
	// Answer watcher and hang guard; a stuck run counts as a mismatch.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			mismatches++;
			print_verdict();
		end else begin
			if (rd_pend) cmp8(sfr_rdata, exp_q.pop_front());
			rd_pend <= sfr_rd;
			if (irq) irq_n++;
			if (err) err_n++;
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		{ev_q, rxv, rx_byte, are, asel} = '0;
		thr = 7'h03;
		ee = 1'b1;
		lf = 8'h25;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rdx(MASK_ADDR, MASK_RESET);
		rdx(8'h42, UNMAPPED_READ);
		cpu.wr(MASK_ADDR, 8'h2f);
		rdx(MASK_ADDR, 8'h2f);
		ev(7'h01);
		cmp1(sfd, 1'b1);
		cmp1(flg[4], 1'b1);
		cpu.wr(FLAGS_ADDR, 8'h00);
		cpu.wr(MASK_ADDR, 8'h3f);
		ev(7'h01);
		clk(2);
		cmp8(8'(irq_n), 8'h01);
		$display("test 1 done");
		for (int i = 0; i < 5; i++) begin
			lf = nxt(lf);
			exp_q.push_back(lf);
			rx(lf);
			if (i == 0) cmp1(dma, 1'b1);
			cmp1(ne, 1'b1);
			cmp8(rx_byte_count, 8'(i + 1));
			if (i == 2) clk(2);
			if (i == 2) cmp1(tf, 1'b0);
		end
		clk(2);
		cmp1(tf, 1'b1);
		ev(7'h02);
		clk(1);
		cmp1(sfd, 1'b0);
		for (int i = 0; i < 5; i++) begin
			cpu.rd(DATA_PORT_ADDR);
			#1;
			cmp1(dma, i < 4);
			cmp8(rx_byte_count, 8'(4 - i));
		end
		clk(2);
		cmp1(ne, 1'b0);
		$display("test 2 done");
		@(posedge sys_clk);
		are <= 1'b1;
		thr <= 7'h01;
		ev(7'h01);
		rx(8'h05);
		rx(8'h61);
		rx(8'h88);
		clk(2);
		cmp1(tf, 1'b0);
		ev(7'h04);
		clk(2);
		cmp1(tf, 1'b1);
		ev(7'h08);
		clk(1);
		cmp1(sfd, 1'b0);
		ev(7'h10);
		cmp8(rx_byte_count, 8'h00);
		@(posedge sys_clk);
		are <= 1'b0;
		thr <= 7'h0a;
		rx(8'h01);
		rx(8'h3c);
		ev(7'h02);
		clk(1);
		cmp1(tf, 1'b1);
		rdx(DATA_PORT_ADDR, 8'h01);
		clk(2);
		cmp1(tf, 1'b0);
		ev(7'h10);
		$display("test 3 done");
		for (int i = 0; i < 128; i++) begin
			lf = nxt(lf);
			if (i == 0) b0 = lf;
			if (i == 1) b1 = lf;
			rx(lf);
		end
		cmp8(rx_byte_count, QUEUE_FULL_COUNT);
		rx(8'h77);
		clk(2);
		cmp8(8'(err_n), 8'h01);
		cmp1(ne, 1'b0);
		cmp1(tf, 1'b1);
		rx(8'h99);
		clk(1);
		cmp8(rx_byte_count, QUEUE_FULL_COUNT);
		rdx(DATA_PORT_ADDR, b0);
		ev(7'h10);
		rx(8'h12);
		cmp8(rx_byte_count, 8'h01);
		rdx(DATA_PORT_ADDR, 8'h12);
		// An empty read shows the stale slot at the read pointer and keeps the count.
		rdx(DATA_PORT_ADDR, b1);
		clk(1);
		cmp8(rx_byte_count, 8'h00);
		ev(7'h10);
		$display("test 4 done");
		cpu.wr(DATA_PORT_ADDR, 8'hc3);
		cpu.wr(DATA_PORT_ADDR, 8'h5a);
		clk(1);
		cmp8(tx_head, 8'hc3);
		cmp1(txne, 1'b1);
		ev(7'h20);
		clk(1);
		cmp1(txne, 1'b0);
		cpu.wr(FLAGS_ADDR, 8'h00);
		ev(7'h40);
		clk(1);
		cmp1(flg[6], 1'b0);
		@(posedge sys_clk);
		asel <= 1'b1;
		ev(7'h40);
		clk(1);
		cmp1(flg[6], 1'b1);
		$display("test 5 done");
		print_verdict();
	end
endmodule
